//--- verilog/lcdsd_core.sv
// Command interpreter and segment control for the 80-column LCD segment driver.
// Assumes a host bus and common-driver timing arriving asynchronously on pins.
// Behaviour
// - Each segment picks one of four levels from line bit and alternation.
// - Any edge on the reset pin starts full initialisation.
// - Initialisation: display off, line 0, static off, column 0, page 3, 1/32, flag 1.
// - Reset pin level after initialisation selects 68 or 80 bus style.
// - Rising edge and high level picks 68 style; falling and low picks 80.
// - Reset command restores only start line and page; RAM untouched.
// - Select low write is command, low read is status, high is data.
// - Display on/off gates latched line data; off with static drive on gives power-save.
// - Start line command loads five bits for the top common row.
// - Page command loads page 0 to 3 for host access only.
// - Command with bit 7 low loads the column address.
// - Column counter increments on data access and stops at 50h.
// - Status: busy, column order, display off, initialising, zeros.
// - Data write stores the byte and advances the column.
// - Data read returns the byte; advances only outside read-modify-write.
// - Accesses pass a holding register; reads return the previous fetch.
// - Column order flag 1 maps column n, flag 0 maps column 79-n.
// - Static drive forces the whole display on.
// - Display off with static drive on enters power-save.
// - Duty command picks 1/32 or 1/16 to match the common driver.
// - Read-modify-write command freezes the column on reads.
// - End command leaves the mode and restores the saved column.
// - Line counter presets on alternation change, counts on line latch clock.
`timescale 1ns/1ps
module lcdsd_core
  import lcdsd_pkg::*;
#(
  parameter int COLS = LCDSD_COLS,
  parameter int INIT_CYCLES = LCDSD_INIT_CYCLES
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic rst_sel_pin,
  input wire logic chip_select_n,
  input wire logic data_command_select,
  input wire logic enable_rd_pin,
  input wire logic rw_wr_pin,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  input wire logic line_latch_clock,
  input wire logic frame_alternation_input,
  output logic [159:0] seg_level,
  output logic bus_style_68,
  output logic power_save
);
  // Reset release synchroniser.
  logic rst_s1_reg, rst_s2_reg;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end
  wire rstn = rst_s2_reg;

  // Two-stage synchronisers for every pin input.
  // They reset to the idle pin levels with cs_n high, so no false access or read follows reset.
  logic [5:0] pin_s1_reg, pin_s2_reg;
  logic [7:0] din_s1_reg, din_s2_reg;
  wire [5:0] pins = {rst_sel_pin, chip_select_n, data_command_select, enable_rd_pin,
    rw_wr_pin, line_latch_clock};
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pin_s1_reg <= LCDSD_PIN_IDLE;
      pin_s2_reg <= LCDSD_PIN_IDLE;
      din_s1_reg <= 8'h00;
      din_s2_reg <= 8'h00;
    end else begin
      pin_s1_reg <= pins;
      pin_s2_reg <= pin_s1_reg;
      din_s1_reg <= data_in;
      din_s2_reg <= din_s1_reg;
    end
  end
  logic fr_s1_reg, fr_s2_reg, fr_d_reg, rsel_d_reg, cl_d_reg;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      fr_s1_reg <= 1'b0;
      fr_s2_reg <= 1'b0;
    end else begin
      fr_s1_reg <= frame_alternation_input;
      fr_s2_reg <= fr_s1_reg;
    end
  end
  wire rsel = pin_s2_reg[5];
  wire cs_n = pin_s2_reg[4];
  wire dcs = pin_s2_reg[3];
  wire e_rd = pin_s2_reg[2];
  wire rw_wr = pin_s2_reg[1];
  wire cl = pin_s2_reg[0];

  // Strobe decode per bus style; one access per strobe assertion.
  logic style68_reg, strobe_d_reg;
  wire strobe = style68_reg ? e_rd : (!e_rd || !rw_wr);
  wire is_read = style68_reg ? rw_wr : !e_rd;
  wire access = !cs_n && strobe && !strobe_d_reg;
  wire cmd_wr = access && !dcs && !is_read;
  wire st_rd = access && !dcs && is_read;
  wire dat_wr = access && dcs && !is_read;
  wire dat_rd = access && dcs && is_read;
  wire [7:0] cmd = din_s2_reg;

  // Opcode match helper.
  function automatic logic op_hit(input logic [7:0] b, input logic [7:0] op,
    input logic [7:0] m);
    op_hit = (b & m) == op;
  endfunction

  // Edge detectors and init sequencing.
  logic [3:0] init_cnt_reg;
  wire rst_edge = rsel != rsel_d_reg;
  wire init_busy = init_cnt_reg != 4'h0;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rsel_d_reg <= 1'b0;
      fr_d_reg <= 1'b0;
      cl_d_reg <= 1'b0;
      strobe_d_reg <= 1'b0;
      init_cnt_reg <= 4'h0;
      style68_reg <= 1'b0;
    end else begin
      rsel_d_reg <= rsel;
      fr_d_reg <= fr_s2_reg;
      cl_d_reg <= cl;
      strobe_d_reg <= strobe;
      if (rst_edge) begin
        init_cnt_reg <= 4'(INIT_CYCLES);
      end else if (init_busy) begin
        init_cnt_reg <= init_cnt_reg - 4'h1;
      end
      if (init_cnt_reg == 4'h1) begin
        style68_reg <= rsel;
      end
    end
  end

  // Mode registers and address counters.
  logic disp_on_reg, static_reg, adc_reg, duty32_reg, rmw_reg;
  logic [4:0] start_line_reg;
  logic [1:0] page_reg;
  logic [6:0] col_reg, col_save_reg;
  wire col_step = (dat_wr || (dat_rd && !rmw_reg)) && col_reg != LCDSD_COL_STOP;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      disp_on_reg <= 1'b0;
      static_reg <= 1'b0;
      adc_reg <= 1'b1;
      duty32_reg <= 1'b1;
      rmw_reg <= 1'b0;
      start_line_reg <= LCDSD_LINE_RESET;
      page_reg <= LCDSD_PAGE_RESET;
      col_reg <= LCDSD_COL_RESET;
      col_save_reg <= LCDSD_COL_RESET;
    end else if (init_cnt_reg == 4'(INIT_CYCLES)) begin
      disp_on_reg <= 1'b0;
      static_reg <= 1'b0;
      adc_reg <= 1'b1;
      duty32_reg <= 1'b1;
      rmw_reg <= 1'b0;
      start_line_reg <= LCDSD_LINE_RESET;
      page_reg <= LCDSD_PAGE_RESET;
      col_reg <= LCDSD_COL_RESET;
    end else if (cmd_wr) begin
      if (!cmd[7]) begin
        col_reg <= cmd[6:0];
      end else if (op_hit(cmd, LCDSD_OP_DISP, LCDSD_MASK_BIT0)) begin
        disp_on_reg <= cmd[0];
      end else if (op_hit(cmd, LCDSD_OP_ADC, LCDSD_MASK_BIT0)) begin
        adc_reg <= !cmd[0];
      end else if (op_hit(cmd, LCDSD_OP_STATIC, LCDSD_MASK_BIT0)) begin
        static_reg <= cmd[0];
      end else if (op_hit(cmd, LCDSD_OP_DUTY, LCDSD_MASK_BIT0)) begin
        duty32_reg <= cmd[0];
      end else if (cmd == LCDSD_OP_RMW) begin
        rmw_reg <= 1'b1;
        col_save_reg <= col_reg;
      end else if (cmd == LCDSD_OP_END) begin
        rmw_reg <= 1'b0;
        col_reg <= col_save_reg;
      end else if (cmd == LCDSD_OP_RESET) begin
        start_line_reg <= LCDSD_LINE_RESET;
        page_reg <= LCDSD_PAGE_RESET;
      end else if (op_hit(cmd, LCDSD_OP_PAGE, LCDSD_MASK_PAGE)) begin
        page_reg <= cmd[1:0];
      end else if (op_hit(cmd, LCDSD_OP_LINE, LCDSD_MASK_LINE)) begin
        start_line_reg <= cmd[4:0];
      end
      // Other command bytes fall through untouched.
    end else if (col_step) begin
      col_reg <= col_reg + 7'h01;
    end
  end

  // Holding register pipeline between the bus and the RAM.
  lcdsd_ram_if rif ();
  logic hold_pend_reg;
  logic [1:0] hold_page_reg;
  logic [6:0] hold_col_reg;
  logic [7:0] hold_data_reg, fetch_reg;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      hold_pend_reg <= 1'b0;
      hold_page_reg <= 2'h0;
      hold_col_reg <= 7'h00;
      hold_data_reg <= 8'h00;
      fetch_reg <= 8'h00;
    end else begin
      if (dat_wr) begin
        hold_pend_reg <= col_reg != LCDSD_COL_STOP;
        hold_page_reg <= page_reg;
        hold_col_reg <= col_reg;
        hold_data_reg <= cmd;
      end else if (access && hold_pend_reg) begin
        hold_pend_reg <= 1'b0;
      end
      if (dat_rd) begin
        fetch_reg <= rif.rd_data;
      end
    end
  end
  assign rif.wr_en = access && hold_pend_reg;
  assign rif.wr_page = hold_page_reg;
  assign rif.wr_col = hold_col_reg;
  assign rif.wr_data = hold_data_reg;
  assign rif.rd_page = page_reg;
  assign rif.rd_col = col_reg;

  lcdsd_ram #(.COLS(COLS), .PAGES(LCDSD_PAGES)) u_ram (
    .ref_clk(ref_clk),
    .bus(rif.ram)
  );

  // Bus read answer: previous fetch for data, live status for status.
  wire [7:0] status_byte = {init_busy, adc_reg, !disp_on_reg, init_busy, 4'h0};
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      data_out <= 8'h00;
      data_oe <= 1'b0;
    end else begin
      if (st_rd) begin
        data_out <= status_byte;
      end else if (dat_rd) begin
        data_out <= fetch_reg;
      end
      data_oe <= !cs_n && strobe && is_read;
    end
  end

  // Line counter preset on alternation change, counts on line latch rising edge.
  logic [4:0] line_reg;
  logic [COLS-1:0] latch_reg;
  wire [4:0] duty_mask = duty32_reg ? 5'h1f : 5'h0f;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      line_reg <= LCDSD_LINE_RESET;
      latch_reg <= '0;
    end else if (fr_s2_reg != fr_d_reg) begin
      line_reg <= start_line_reg;
    end else if (cl && !cl_d_reg) begin
      latch_reg <= rif.line_bits;
      line_reg <= start_line_reg + ((line_reg - start_line_reg + 5'h01) & duty_mask);
    end
  end
  assign rif.line_addr = line_reg;

  // Segment level select with column order, static and power-save overrides.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      seg_level <= '0;
      power_save <= 1'b0;
      bus_style_68 <= 1'b0;
    end else begin
      power_save <= !disp_on_reg && static_reg;
      bus_style_68 <= style68_reg;
      for (int n = 0; n < COLS; n++) begin
        logic px;
        lcdsd_level_e lv;
        px = adc_reg ? latch_reg[n] : latch_reg[COLS-1-n];
        px = static_reg || (disp_on_reg && px);
        if (!disp_on_reg && static_reg) begin
          lv = LCDSD_LVL_VDD;
        end else if (fr_s2_reg) begin
          lv = px ? LCDSD_LVL_VDD : LCDSD_LVL_V2;
        end else begin
          lv = px ? LCDSD_LVL_V5 : LCDSD_LVL_V3;
        end
        seg_level[2*n +: 2] <= lv;
      end
    end
  end
endmodule

//--- verilog/lcdsd_pkg.sv
// Package with opcodes, field layout, reset values and geometry of the segment driver.
// Assumes a single 200 MHz clock domain in every file that imports it.
package lcdsd_pkg;
  localparam int LCDSD_COLS = 80;
  localparam int LCDSD_PAGES = 4;
  localparam logic [6:0] LCDSD_COL_STOP = 7'h50;
  localparam logic [6:0] LCDSD_COL_LAST = 7'h4f;
  localparam logic [6:0] LCDSD_COL_RESET = 7'h00;
  localparam logic [1:0] LCDSD_PAGE_RESET = 2'h3;
  localparam logic [4:0] LCDSD_LINE_RESET = 5'h00;
  // Idle pin levels {reset select, cs_n, select, E or RD, R/W or WR, line clock}.
  localparam logic [5:0] LCDSD_PIN_IDLE = 6'h1a;
  // Command opcodes with their option bits masked off.
  localparam logic [7:0] LCDSD_OP_DISP = 8'hae;
  localparam logic [7:0] LCDSD_OP_ADC = 8'ha0;
  localparam logic [7:0] LCDSD_OP_STATIC = 8'ha4;
  localparam logic [7:0] LCDSD_OP_DUTY = 8'ha8;
  localparam logic [7:0] LCDSD_OP_RMW = 8'he0;
  localparam logic [7:0] LCDSD_OP_END = 8'hee;
  localparam logic [7:0] LCDSD_OP_RESET = 8'he2;
  localparam logic [7:0] LCDSD_MASK_BIT0 = 8'hfe;
  localparam logic [7:0] LCDSD_OP_PAGE = 8'hb8;
  localparam logic [7:0] LCDSD_MASK_PAGE = 8'hfc;
  localparam logic [7:0] LCDSD_OP_LINE = 8'hc0;
  localparam logic [7:0] LCDSD_MASK_LINE = 8'he0;
  // Status byte bit positions.
  localparam int LCDSD_ST_BUSY = 7;
  localparam int LCDSD_ST_ADC = 6;
  localparam int LCDSD_ST_OFF = 5;
  localparam int LCDSD_ST_INIT = 4;
  // Length of the initialisation cycle after a reset edge, in clocks.
  localparam int LCDSD_INIT_CYCLES = 4;
  // Segment drive level codes.
  typedef enum logic [1:0] {
    LCDSD_LVL_VDD = 2'h0,
    LCDSD_LVL_V2 = 2'h1,
    LCDSD_LVL_V3 = 2'h2,
    LCDSD_LVL_V5 = 2'h3
  } lcdsd_level_e;
endpackage

//--- verilog/lcdsd_ram_if.sv
// Interface joining the command core to the display RAM.
// Assumes both ends share ref_clk.
`timescale 1ns/1ps
interface lcdsd_ram_if;
  logic wr_en;
  logic [1:0] wr_page;
  logic [6:0] wr_col;
  logic [7:0] wr_data;
  logic [1:0] rd_page;
  logic [6:0] rd_col;
  logic [7:0] rd_data;
  logic [4:0] line_addr;
  logic [79:0] line_bits;
  modport core (output wr_en, wr_page, wr_col, wr_data, rd_page, rd_col, line_addr,
    input rd_data, line_bits);
  modport ram (input wr_en, wr_page, wr_col, wr_data, rd_page, rd_col, line_addr,
    output rd_data, line_bits);
endinterface

//--- verilog/lcdsd_ram.sv
// Display RAM of 4 pages by 80 columns by 8 bits, in flip-flops.
// Assumes the core keeps write columns below the stop value.
`timescale 1ns/1ps
module lcdsd_ram
  import lcdsd_pkg::*;
#(
  parameter int COLS = LCDSD_COLS,
  parameter int PAGES = LCDSD_PAGES
) (
  input wire logic ref_clk,
  lcdsd_ram_if.ram bus
);
  logic [7:0] mem [PAGES][COLS];

  // Host writes; locations outside the array are never touched.
  always_ff @(posedge ref_clk) begin
    if (bus.wr_en && (int'(bus.wr_col) < COLS)) begin
      mem[bus.wr_page][bus.wr_col] <= bus.wr_data;
    end
  end

  // Host read port; the stop column returns zero.
  always_comb begin
    bus.rd_data = 8'h00;
    if (int'(bus.rd_col) < COLS) begin
      bus.rd_data = mem[bus.rd_page][bus.rd_col];
    end
  end

  // Line read port picks one bit per column from the page of the line.
  always_comb begin
    for (int c = 0; c < COLS; c++) begin
      bus.line_bits[c] = mem[bus.line_addr[4:3]][c][bus.line_addr[2:0]];
    end
  end
endmodule

//--- dv/lcdsd_partner.sv
// Model of the companion common driver: free-running line clock and frame alternation.
// Assumes it feeds the line clock and alternation pins of the segment driver core.
`timescale 1ns/1ps
module lcdsd_partner
#(
  parameter int LINE_NS = 400,
  parameter int DUTY = 32
) (
  output logic line_latch_clock,
  output logic frame_alternation_input
);
  int lines;
  // Alternation flips once per frame of DUTY lines, so it is a 50% clock locked to frames.
  initial begin
    line_latch_clock = 1'b0;
    frame_alternation_input = 1'b0;
    lines = 0;
    forever begin
      #(LINE_NS / 2);
      line_latch_clock = 1'b1;
      #(LINE_NS / 2);
      line_latch_clock = 1'b0;
      lines++;
      if (lines % DUTY == 0) begin
        frame_alternation_input = !frame_alternation_input;
      end
    end
  end
endmodule

//--- dv/lcdsd_core_props.sv
// Checker for the segment driver core, watching only its top-level ports.
// Assumes a single ref_clk domain and the raw resetn pin as its reset.
`timescale 1ns/1ps
module lcdsd_core_props
  import lcdsd_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic rst_sel_pin,
  input wire logic chip_select_n,
  input wire logic rw_wr_pin,
  input wire logic [7:0] data_out,
  input wire logic data_oe,
  input wire logic [159:0] seg_level,
  input wire logic bus_style_68,
  input wire logic power_save
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);
  // A reset pin edge followed by a steady level.
  sequence s_pin_rise;
    $rose(rst_sel_pin) ##1 $stable(rst_sel_pin) [*8];
  endsequence
  sequence s_pin_fall;
    $fell(rst_sel_pin) ##1 $stable(rst_sel_pin) [*8];
  endsequence
  // Bus left alone and no reset pin activity.
  sequence s_bus_quiet;
    (chip_select_n && $stable(rst_sel_pin)) [*4];
  endsequence
  a_style_rise_68: assert property (s_pin_rise |-> ##2 bus_style_68)
    else $error("bus style not 68 after rising reset pin");
  a_style_fall_80: assert property (s_pin_fall |-> ##2 !bus_style_68)
    else $error("bus style not 80 after falling reset pin");
  a_oe_from_read: assert property ($rose(data_oe) |->
    $past(chip_select_n, 2) == 1'b0 && $past(rw_wr_pin, 2))
    else $error("data bus driven without a read cycle");
  a_no_oe_write: assert property ((!chip_select_n && !rw_wr_pin) [*4] |-> !data_oe)
    else $error("data bus driven during a write cycle");
  a_oe_idle_off: assert property (chip_select_n [*5] |-> !data_oe)
    else $error("data bus driven while deselected");
  a_out_hold_idle: assert property (s_bus_quiet |=> $stable(data_out))
    else $error("read data changed without a read");
  a_save_hold_idle: assert property ((chip_select_n && $stable(rst_sel_pin)) [*6] |->
    $stable(power_save))
    else $error("power save changed without a command");
  a_save_seg_vdd: assert property (power_save [*3] |-> seg_level == 160'h0)
    else $error("segments not at VDD in power save");
endmodule
bind lcdsd_core lcdsd_core_props lcdsd_core_props_i (.ref_clk(ref_clk), .resetn(resetn),
  .rst_sel_pin(rst_sel_pin), .chip_select_n(chip_select_n), .rw_wr_pin(rw_wr_pin),
  .data_out(data_out), .data_oe(data_oe), .seg_level(seg_level),
  .bus_style_68(bus_style_68), .power_save(power_save));

//--- dv/lcd_segment_driver_cmd_test.sv
// Self-checking bench: host bus tasks, reference model of registers and RAM, scenarios.
// Assumes the core, its RAM, the partner model and the checker bind are compiled first.
`timescale 1ns/1ps
module lcd_segment_driver_cmd_test;
  import lcdsd_pkg::*;
  logic ref_clk, resetn, rst_sel_pin, chip_select_n, data_command_select;
  logic enable_rd_pin, rw_wr_pin, line_latch_clock, frame_alternation_input;
  logic data_oe, bus_style_68, power_save, disp_off, adc, stat, rmw;
  logic [7:0] data_in, data_out, rd_val, fetch;
  logic [7:0] mem [4][80];
  logic [7:0] ops [10] = '{8'haf, 8'ha1, 8'hff, 8'ha8, 8'ha9, 8'ha0, 8'ha5, 8'hae, 8'haf, 8'ha4};
  logic [159:0] seg_level;
  int mismatches, total_checks, col, page, rmw_col;
  lcdsd_core lcdsd_core_i (.ref_clk(ref_clk), .resetn(resetn), .rst_sel_pin(rst_sel_pin),
    .chip_select_n(chip_select_n), .data_command_select(data_command_select),
    .enable_rd_pin(enable_rd_pin), .rw_wr_pin(rw_wr_pin), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe), .line_latch_clock(line_latch_clock),
    .frame_alternation_input(frame_alternation_input), .seg_level(seg_level),
    .bus_style_68(bus_style_68), .power_save(power_save));
  lcdsd_partner lcdsd_partner_i (.line_latch_clock(line_latch_clock),
    .frame_alternation_input(frame_alternation_input));
  // Free-running 200 MHz clock.
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = !ref_clk;
  end
  task automatic check(string what, logic [159:0] seen, logic [159:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // One bus cycle; held for five clocks so the synchronisers see it, then released.
  task automatic access(input logic dc, input logic rd, input logic [7:0] d);
    @(posedge ref_clk);
    #1;
    chip_select_n = 1'b0;
    data_command_select = dc;
    data_in = d;
    rw_wr_pin = rd;
    enable_rd_pin = bus_style_68 | !rd;
    repeat (5) @(posedge ref_clk);
    #1;
    rd_val = data_out;
    chip_select_n = 1'b1;
    rw_wr_pin = 1'b1;
    enable_rd_pin = !bus_style_68;
    repeat (5) @(posedge ref_clk);
    #1;
  endtask
  // Command write plus its effect on the reference model.
  task automatic cmd(input logic [7:0] c);
    access(1'b0, 1'b0, c);
    casez (c)
      8'b0???????: col = c[6:0];
      8'b101110??: page = c[1:0];
      8'b1010111?: disp_off = !c[0];
      8'b1010000?: adc = !c[0];
      8'b1010010?: stat = c[0];
      8'he2: page = 3;
      8'he0: begin
        rmw = 1'b1;
        rmw_col = col;
      end
      8'hee: begin
        rmw = 1'b0;
        col = rmw_col;
      end
      default: ;
    endcase
  endtask
  task automatic wr(input logic [7:0] d);
    access(1'b1, 1'b0, d);
    if (col < 80) mem[page][col] = d;
    if (col < 80) col++;
  endtask
  // Data read returns the byte fetched by the previous read.
  task automatic rd(input bit cmp);
    access(1'b1, 1'b1, 8'h00);
    if (cmp && !$isunknown(fetch)) check("read data", rd_val, fetch);
    fetch = (col < 80) ? mem[page][col] : 8'hxx;
    if (col < 80 && !rmw) col++;
  endtask
  task automatic status;
    access(1'b0, 1'b1, 8'h00);
    check("status", rd_val, {1'b0, adc, disp_off, 5'h00});
  endtask
  // Watchdog against a hung run.
  initial begin
    repeat (40000) @(posedge ref_clk);
    mismatches++;
    test_done;
  end
  initial begin
    void'($urandom(32'h9acd));
    {resetn, rst_sel_pin, data_command_select, data_in} = '0;
    {chip_select_n, enable_rd_pin, rw_wr_pin} = 3'h7;
    repeat (8) @(posedge ref_clk);
    #1;
    resetn = 1'b1;
    repeat (4) @(posedge ref_clk);
    // Rising pin edge selects the 68-style bus, then a falling edge the 80-style bus.
    for (int k = 0; k < 2; k++) begin
      @(posedge ref_clk);
      #1;
      rst_sel_pin = !rst_sel_pin;
      enable_rd_pin = !rst_sel_pin;
      repeat (12) @(posedge ref_clk);
      disp_off = 1'b1;
      adc = 1'b1;
      stat = 1'b0;
      rmw = 1'b0;
      page = 3;
      col = 0;
      status;
      check("style", bus_style_68, rst_sel_pin);
      cmd(8'haf);
      status;
    end
    $display("test init done");
    // Column 0 of a random page, then three writes across the stop column.
    cmd(8'hb8 | 8'($urandom_range(3)));
    cmd(8'h00);
    wr(8'($urandom));
    cmd(8'h4e);
    repeat (3) wr(8'($urandom));
    cmd(8'h4e);
    rd(1'b0);
    repeat (3) rd(1'b1);
    cmd(8'h00);
    rd(1'b0);
    rd(1'b1);
    $display("test column stop done");
    // Reads in read-modify-write mode hold the column; the end command restores it.
    cmd(8'h10);
    for (int k = 0; k < 2; k++) begin
      cmd(8'he0);
      rd(1'b0);
      repeat (2) rd(1'b1);
      wr(8'($urandom));
      cmd(8'hee);
    end
    rd(1'b0);
    rd(1'b1);
    $display("test modify done");
    // Mode commands, an unknown byte and the power-save pair, each followed by status.
    foreach (ops[i]) begin
      cmd(ops[i]);
      status;
      check("save", power_save, disp_off & stat);
      if (stat && !disp_off) begin
        // Look while the line clock is high, far from any alternation flip.
        for (int w = 0; w < 200 && !line_latch_clock; w++) @(posedge ref_clk);
        #1;
        if (!line_latch_clock) mismatches++;
        check("seg", seg_level[1:0],
          frame_alternation_input ? LCDSD_LVL_VDD : LCDSD_LVL_V5);
      end
    end
    $display("test modes done");
    // Reset command sends the page back to 3 and leaves the RAM as it was.
    cmd(8'hb8);
    cmd(8'h00);
    wr(8'h5a);
    cmd(8'he2);
    cmd(8'h00);
    wr(8'ha5);
    for (int p = 0; p < 4; p += 3) begin
      cmd(8'hb8 | 8'(p));
      cmd(8'h00);
      rd(1'b0);
      rd(1'b1);
    end
    $display("test reset command done");
    test_done;
  end
endmodule
